/* ota_pkg.sv */
/*
 * Package for the ON-time accumulator: timing, widths, mode encodings.
 * Assumes a single 100 MHz clock domain.
 */
package ota_pkg;
	localparam int          CLK_HZ          = 100_000_000;
	localparam int          SAMPLE_PERIOD_S = 1;
	localparam int          SAMPLE_CYCLES   = CLK_HZ * SAMPLE_PERIOD_S;
	localparam int          TOTAL_W         = 32;
	localparam int          NUM_POINTS      = 16;
	localparam int          PT_W            = 4;
	localparam int          MODE_W          = 1;
	localparam logic [31:0] TOTAL_MAX       = 32'hFFFFFFFF;
	localparam logic [31:0] TOTAL_RESET     = 32'h00000000;
	localparam logic [31:0] THRESH_OFF      = 32'h00000000;

	typedef enum logic [0:0] {
		OTA_MODE_COUNT = 1'h0,
		OTA_MODE_TIME  = 1'h1
	} ota_mode_t;
endpackage : ota_pkg

/* ota_accum.sv */
/*
 * ON-time accumulator / operation counter for every monitored I/O point.
 * Assumes point levels arrive asynchronously from pins; config strobes come
 * from same-clock logic; non-volatile backing storage mirrors the totals array.
 */
// Overview of operation
// - Keep a separate ON-time total per point, retained in storage
// - Totals are unsigned 32-bit seconds or operation counts, zero to all ones
// - Sample points about every second; add one per ON sample
// - Each point runs time accumulation or edge counting, never both
// - Changing a point's mode clears its collected value
// - No counting while I/O power is absent; totals change only on a clear request or a mode change
// - Mode and alarm threshold are settable per point
// - Zero threshold disables the comparison for that point
// - Clear request zeroes only the addressed point's total
// - Every point's value is readable by address
`timescale 1ns/1ps
module ota_accum
#(
	parameter int NPTS       = ota_pkg::NUM_POINTS,
	parameter int TICK_CYCLES = ota_pkg::SAMPLE_CYCLES
) (
	input  wire logic                       mclk,
	input  wire logic                       rst_n,
	input  wire logic [NPTS-1:0]            point_in,
	input  wire logic                       io_power_ok,
	input  wire logic                       cfg_wr,
	input  wire logic [ota_pkg::PT_W-1:0]   cfg_point,
	input  wire logic                       cfg_mode,
	input  wire logic [31:0]                cfg_threshold,
	input  wire logic                       clear_req,
	input  wire logic [ota_pkg::PT_W-1:0]   clear_point,
	input  wire logic [ota_pkg::PT_W-1:0]   rd_point,
	output logic      [31:0]                present_total,
	output logic      [31:0]                threshold_setting,
	output logic                            rd_mode,
	output logic      [NPTS-1:0]            alarm
);
	import ota_pkg::*;

	function automatic logic [31:0] sat_inc(input logic [31:0] v);
		sat_inc = (v == TOTAL_MAX) ? v : v + 32'h00000001;
	endfunction : sat_inc

	logic [NPTS-1:0] sync1;
	logic [NPTS-1:0] sync2;
	logic [NPTS-1:0] sync3;
	logic [NPTS-1:0] level;
	logic [NPTS-1:0] level_d;
	logic [31:0]     totals [NPTS];
	logic [31:0]     thresh [NPTS];
	logic [NPTS-1:0] mode;
	logic [31:0]     tick_cnt;
	logic            pwr1;
	logic            pwr2;
	logic            pwr3;
	logic            pwr;

	wire tick_wrap = (tick_cnt == 32'(TICK_CYCLES - 1));
	wire tick_en   = tick_wrap && pwr;

	// Three-stage pin synchronisers, change accepted when stages 2 and 3 agree
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
			level <= '0;
			pwr1  <= 1'b0;
			pwr2  <= 1'b0;
			pwr3  <= 1'b0;
			pwr   <= 1'b0;
		end else begin
			sync1 <= point_in;
			sync2 <= sync1;
			sync3 <= sync2;
			level <= (sync2 & sync3) | (level & (sync2 | sync3));
			pwr1  <= io_power_ok;
			pwr2  <= pwr1;
			pwr3  <= pwr2;
			pwr   <= (pwr2 & pwr3) | (pwr & (pwr2 | pwr3));
		end
	end

	// About one-second sample tick
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			tick_cnt <= '0;
		end else if (tick_wrap) begin
			tick_cnt <= '0;
		end else begin
			tick_cnt <= tick_cnt + 32'h00000001;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			level_d <= '0;
		end else if (pwr) begin
			level_d <= level;
		end
	end

	// Per-point accumulation, configuration and clear
	for (genvar i = 0; i < NPTS; i++) begin : g_pt
		wire cfg_hit   = cfg_wr && (cfg_point == PT_W'(i));
		wire mode_chg  = cfg_hit && (cfg_mode != mode[i]);
		wire clr_hit   = clear_req && (clear_point == PT_W'(i));
		wire time_inc  = tick_en && mode[i] && level[i];
		wire count_inc = pwr && !mode[i] && level[i] && !level_d[i];

		always_ff @(posedge mclk) begin
			if (!rst_n) begin
				totals[i] <= TOTAL_RESET;
				thresh[i] <= THRESH_OFF;
				mode[i]   <= OTA_MODE_TIME;
			end else begin
				if (cfg_hit) begin
					thresh[i] <= cfg_threshold;
					mode[i]   <= cfg_mode;
				end
				if (mode_chg || clr_hit) begin
					totals[i] <= TOTAL_RESET;
				end else if (time_inc || count_inc) begin
					totals[i] <= sat_inc(totals[i]);
				end
			end
		end

		// Alarm compare, skipped at zero threshold
		always_ff @(posedge mclk) begin
			if (!rst_n) begin
				alarm[i] <= 1'b0;
			end else begin
				alarm[i] <= (thresh[i] != THRESH_OFF) && (totals[i] >= thresh[i]);
			end
		end

		property p_excl;
			@(posedge mclk) disable iff (!rst_n)
				(tick_en && !mode[i] && level_d[i] && !clr_hit && !cfg_hit) |=> $stable(totals[i]);
		endproperty
		a_excl: assert property (p_excl) else $error("Time added in count mode");
	end

	// Readback
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			present_total     <= '0;
			threshold_setting <= '0;
			rd_mode           <= 1'b0;
		end else begin
			present_total     <= totals[rd_point];
			threshold_setting <= thresh[rd_point];
			rd_mode           <= mode[rd_point];
		end
	end

	property p_no_pwr_freeze;
		@(posedge mclk) disable iff (!rst_n)
			(!pwr && !clear_req && !cfg_wr) |=> $stable(totals[0]);
	endproperty
	a_no_pwr_freeze: assert property (p_no_pwr_freeze) else $error("Total changed with power off");

	sequence s_clear0;
		clear_req && (clear_point == PT_W'(0));
	endsequence

	sequence s_zero0;
		totals[0] == TOTAL_RESET;
	endsequence

	property p_clear;
		@(posedge mclk) disable iff (!rst_n)
			s_clear0 |=> s_zero0;
	endproperty
	a_clear: assert property (p_clear) else $error("Clear did not zero total");

	property p_clear_iso;
		@(posedge mclk) disable iff (!rst_n)
			(clear_req && clear_point == PT_W'(0) && !cfg_wr && totals[1] != TOTAL_RESET)
				|=> (totals[1] != TOTAL_RESET);
	endproperty
	a_clear_iso: assert property (p_clear_iso) else $error("Clear touched another point");

	property p_mode_clear;
		@(posedge mclk) disable iff (!rst_n)
			(cfg_wr && cfg_point == PT_W'(0) && cfg_mode != mode[0]) |=> (totals[0] == TOTAL_RESET);
	endproperty
	a_mode_clear: assert property (p_mode_clear) else $error("Mode change did not clear");

	property p_sat;
		@(posedge mclk) disable iff (!rst_n)
			(totals[0] == TOTAL_MAX && !clear_req && !cfg_wr) |=> (totals[0] == TOTAL_MAX);
	endproperty
	a_sat: assert property (p_sat) else $error("Total wrapped");

	property p_zero_thr;
		@(posedge mclk) disable iff (!rst_n)
			(thresh[0] == THRESH_OFF) |=> !alarm[0];
	endproperty
	a_zero_thr: assert property (p_zero_thr) else $error("Alarm with zero threshold");

	property p_alarm;
		@(posedge mclk) disable iff (!rst_n)
			(thresh[0] != THRESH_OFF && totals[0] >= thresh[0]) |=> alarm[0];
	endproperty
	a_alarm: assert property (p_alarm) else $error("Alarm not raised");

	property p_tick_step;
		@(posedge mclk) disable iff (!rst_n)
			(tick_en && mode[0] && level[0] && totals[0] != TOTAL_MAX && !clear_req && !cfg_wr)
				|=> (totals[0] == $past(totals[0]) + 32'h00000001);
	endproperty
	a_tick_step: assert property (p_tick_step) else $error("ON sample not added");

	property p_edge_step;
		@(posedge mclk) disable iff (!rst_n)
			(pwr && !mode[1] && level[1] && !level_d[1] && totals[1] != TOTAL_MAX && !clear_req && !cfg_wr)
				|=> (totals[1] == $past(totals[1]) + 32'h00000001);
	endproperty
	a_edge_step: assert property (p_edge_step) else $error("Operation not counted");

	property p_read;
		@(posedge mclk) disable iff (!rst_n)
			(rd_point == PT_W'(0)) |=> (present_total == $past(totals[0]));
	endproperty
	a_read: assert property (p_read) else $error("Readback mismatch");
endmodule : ota_accum

/* tb.sv */
/*
 * Self-checking bench for ota_accum with a short sample tick.
 * Assumes ota_pkg is compiled first; one 100 MHz clock.
 */
`timescale 1ns/1ps
module tb;
	import ota_pkg::*;
	localparam int TK = 20;
	logic                  mclk, rst_n, io_power_ok, cfg_wr, cfg_mode, clear_req, rd_mode;
	logic [NUM_POINTS-1:0] point_in, alarm;
	logic [PT_W-1:0]       cfg_point, clear_point, rd_point;
	logic [31:0]           cfg_threshold, present_total, threshold_setting, a, b;
	int                    err_total, checked;

	ota_accum #(.NPTS(NUM_POINTS), .TICK_CYCLES(TK)) u_dut (.mclk(mclk), .rst_n(rst_n),
		.point_in(point_in), .io_power_ok(io_power_ok), .cfg_wr(cfg_wr), .cfg_point(cfg_point),
		.cfg_mode(cfg_mode), .cfg_threshold(cfg_threshold), .clear_req(clear_req),
		.clear_point(clear_point), .rd_point(rd_point), .present_total(present_total),
		.threshold_setting(threshold_setting), .rd_mode(rd_mode), .alarm(alarm));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic step(input int n);
		repeat (n) @(posedge mclk);
	endtask : step

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			err_total++;
			$display("ERROR %0t: saw %h expected %h", $time, s, e);
		end
	endtask : chk

	task automatic rd(input logic [PT_W-1:0] p);
		@(posedge mclk);
		rd_point <= p;
		step(3);
		#1;
	endtask : rd

	task automatic cfg(input logic [PT_W-1:0] p, input logic m, input logic [31:0] t);
		@(posedge mclk);
		cfg_point     <= p;
		cfg_mode      <= m;
		cfg_threshold <= t;
		cfg_wr        <= 1'b1;
		@(posedge mclk);
		cfg_wr <= 1'b0;
	endtask : cfg

	task automatic end_of_test();
		$display("Mismatches %0d, checks %0d", err_total, checked);
		if (err_total == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_of_test

	initial begin
		#50000;
		err_total++;
		end_of_test();
	end

	initial begin
		{rst_n, io_power_ok, cfg_wr, cfg_mode, clear_req} = 5'h00;
		{point_in, cfg_point, clear_point, rd_point, cfg_threshold} = '0;
		step(10);
		rst_n <= 1'b1;
		step(2);
		rd(4'h0);
		chk(present_total, 32'h00000000);
		chk(threshold_setting, 32'h00000000);
		chk({31'h0, rd_mode}, 32'h00000001);
		chk({16'h0, alarm}, 32'h00000000);
		@(posedge mclk);
		point_in <= '1;
		step(5 * TK);
		rd(4'h0);
		chk(present_total, 32'h00000000);
		@(posedge mclk);
		io_power_ok <= 1'b1;
		step(3 * TK);
		rd(4'h0);
		a = present_total;
		step(TK);
		#1;
		chk(present_total, a + 32'h1);
		cfg(4'h0, 1'b1, a + 32'h4);
		cfg(4'h1, 1'b1, 32'h00000000);
		step(5 * TK);
		#1;
		chk({30'h0, alarm[1:0]}, 32'h00000001);
		rd(4'h0);
		chk(threshold_setting, a + 32'h4);
		@(posedge mclk);
		point_in <= '0;
		step(10);
		rd(4'h1);
		b = present_total;
		chk({31'h0, b > a}, 32'h00000001);
		@(posedge mclk);
		clear_point <= 4'h0;
		clear_req   <= 1'b1;
		@(posedge mclk);
		clear_req <= 1'b0;
		rd(4'h0);
		chk(present_total, 32'h00000000);
		chk({31'h0, alarm[0]}, 32'h00000000);
		rd(4'h1);
		chk(present_total, b);
		cfg(4'h1, 1'b0, 32'h00000000);
		rd(4'h1);
		chk(present_total, 32'h00000000);
		chk({31'h0, rd_mode}, 32'h00000000);
		repeat (3) begin
			@(posedge mclk);
			point_in[1] <= 1'b1;
			step(8);
			point_in[1] <= 1'b0;
			step(8);
		end
		point_in[1] <= 1'b1;
		step(3 * TK);
		rd(4'h1);
		chk(present_total, 32'h00000004);
		@(posedge mclk);
		io_power_ok <= 1'b0;
		step(10);
		point_in[2] <= 1'b1;
		step(3 * TK);
		rd(4'h2);
		chk(present_total, b);
		@(posedge mclk);
		io_power_ok <= 1'b1;
		step(3 * TK);
		rd(4'h2);
		chk({31'h0, present_total > b}, 32'h00000001);
		rd(4'h1);
		chk(present_total, 32'h00000004);
		end_of_test();
	end
endmodule : tb
